//--- core/shutdown_regs.svh
// Purpose: offsets, field positions, reset values and sampling counts
// Assumes: 16-bit registers on a plain strobe port with a 20-bit byte address
// Notes:   definitions only
`ifndef SHUTDOWN_REGS_SVH
`define SHUTDOWN_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADDR_W              20
`define CTRL_A_OFFSET       20'h8C4C0
`define CTRL_B_OFFSET       20'h8C4C8
`define IRQ_STATUS_OFFSET   20'h8C4D0
`define IRQ_MASK_OFFSET     20'h8C4D4

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define DATA_W              16
`define MODE_MSB            1
`define MODE_LSB            0
`define IRQ_EN_BIT          8
`define HIZ_EN_BIT          9
`define FLAG_BIT            12
`define IRQ_A_BIT           0
`define IRQ_B_BIT           1
`define CTRL_RESET          16'h0000
`define IRQ_RESET           2'h0

// ----------------------------------------------------------------------
// sampling
// ----------------------------------------------------------------------
`define DIV_CNT_W           7
`define DIV_MASK_8          7'h07
`define DIV_MASK_16         7'h0F
`define DIV_MASK_128        7'h7F
`define LOW_CNT_W           5
`define LOW_SAMPLE_LAST     5'h0F
`define LOW_SAMPLE_COUNT    5'h10

`endif

//--- core/shutdown_pkg.sv
// Purpose: types shared by the shutdown input detection files
// Assumes: nothing
// Notes:   mode codes follow the order 00 edge, 01 /8, 10 /16, 11 /128
package shutdown_pkg;

	typedef enum logic [1:0]
	{
		mode_falling_edge,
		mode_div8,
		mode_div16,
		mode_div128
	} detect_mode_type;

endpackage

//--- core/sample_rate_divider.sv
// Purpose: one-cycle sampling enables at core clock /8, /16 and /128
// Assumes: single clock, synchronous active-high reset
// Notes:   all three enables come from one free-running counter
`timescale 1ns/1ps
`include "shutdown_regs.svh"

module sample_rate_divider
(
	input  wire logic core_clk_i,
	input  wire logic srst_i,
	output logic      tick8_o,
	output logic      tick16_o,
	output logic      tick128_o
);

	logic [`DIV_CNT_W-1:0] div_cnt;

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + 7'h01;
	end

	assign tick8_o   = (div_cnt & `DIV_MASK_8) == `DIV_MASK_8;
	assign tick16_o  = (div_cnt & `DIV_MASK_16) == `DIV_MASK_16;
	assign tick128_o = div_cnt == `DIV_MASK_128;

endmodule

//--- core/pin_request_detect.sv
// Purpose: synchronise one active-low request pin and detect an accepted request
// Assumes: tick inputs are one-cycle enables on the same clock
// Notes:   accept_o is a one-cycle pulse; pin_high_o is the filtered pin level
`timescale 1ns/1ps
`include "shutdown_regs.svh"

module pin_request_detect
	import shutdown_pkg::*;
(
	input  wire logic            core_clk_i,
	input  wire logic            srst_i,
	input  wire logic            pin_n_i,
	input  wire detect_mode_type mode_i,
	input  wire logic            tick8_i,
	input  wire logic            tick16_i,
	input  wire logic            tick128_i,
	output logic                 accept_o,
	output logic                 pin_high_o
);

	logic                  sync1;
	logic                  sync2;
	logic                  sync3;
	logic                  level;
	logic                  level_prev;
	logic [`LOW_CNT_W-1:0] low_cnt;
	logic                  tick;
	logic                  falling;

	// a pin change counts once the second and third stages agree
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			sync1      <= 1'b1;
			sync2      <= 1'b1;
			sync3      <= 1'b1;
			level      <= 1'b1;
			level_prev <= 1'b1;
		end
		else
		begin
			sync1      <= pin_n_i;
			sync2      <= sync1;
			sync3      <= sync2;
			level      <= (sync2 == sync3) ? sync3 : level;
			level_prev <= level;
		end
	end

	assign tick = (mode_i == mode_div8)   ? tick8_i :
	              (mode_i == mode_div16)  ? tick16_i :
	              (mode_i == mode_div128) ? tick128_i : 1'b0;

	// a high sample restarts the run of low samples
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			low_cnt <= '0;
		else if (tick && level)
			low_cnt <= '0;
		else if (tick && low_cnt != `LOW_SAMPLE_COUNT)
			low_cnt <= low_cnt + 5'h01;
	end

	assign falling    = level_prev & ~level;
	assign accept_o   = (mode_i == mode_falling_edge) ? falling :
	                    (tick & ~level & (low_cnt == `LOW_SAMPLE_LAST));
	assign pin_high_o = level;

endmodule

//--- core/output_shutdown_input_detect.sv
// Purpose: input detection of the output shutdown unit for two request pins
// Assumes: core_clk_i is the peripheral clock at 10 MHz; srst_i is synchronous
// Notes:   hiz request outputs feed the timer output stage; flags feed recovery
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "shutdown_regs.svh"

module output_shutdown_input_detect
	import shutdown_pkg::*;
(
	input  wire logic [`ADDR_W-1:0] reg_addr_i,
	input  wire logic               core_clk_i,
	input  wire logic               srst_i,
	input  wire logic [`DATA_W-1:0] reg_wdata_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	output logic      [`DATA_W-1:0] reg_rdata_o,
	input  wire logic               shutdown_req_pin_a_n_i,
	input  wire logic               shutdown_req_pin_b_n_i,
	output logic                    pin_a_request_flag_o,
	output logic                    pin_b_request_flag_o,
	output logic                    hiz_req_ch34_o,
	output logic                    hiz_req_ch0_o,
	output logic                    irq_o
);

	// ------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------

	// reserved positions stay zero in every read image
	function automatic logic [`DATA_W-1:0] ctrl_image
	(
		input detect_mode_type mode,
		input logic            irq_en,
		input logic            hiz_en,
		input logic            flag
	);
		logic [`DATA_W-1:0] img;
		img = `CTRL_RESET;
		img[`MODE_MSB:`MODE_LSB] = mode;
		img[`IRQ_EN_BIT] = irq_en;
		img[`HIZ_EN_BIT] = hiz_en;
		img[`FLAG_BIT] = flag;
		return img;
	endfunction

	// in sampling modes the pin must be released before a clear
	function automatic logic clear_allowed
	(
		input detect_mode_type mode,
		input logic            pin_high
	);
		return (mode == mode_falling_edge) || pin_high;
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	detect_mode_type    pin_a_detect_mode;
	logic               pin_a_irq_enable;
	logic               pin_a_request_flag;
	logic               cfg_locked_a;
	logic               read_one_a;
	detect_mode_type    pin_b_detect_mode;
	logic               pin_b_irq_enable;
	logic               pin_b_hiz_enable;
	logic               pin_b_request_flag;
	logic               cfg_locked_b;
	logic               read_one_b;
	logic [1:0]         irq_status;
	logic [1:0]         irq_mask;
	logic [`DATA_W-1:0] rdata;
	logic               hiz_a;
	logic               hiz_b;
	logic               irq;

	// ------------------------------------------------------------------
	// sampling enables and pin detectors
	// ------------------------------------------------------------------
	logic tick8;
	logic tick16;
	logic tick128;
	logic accept_a;
	logic accept_b;
	logic pin_high_a;
	logic pin_high_b;

	sample_rate_divider u_divider
	(
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.tick8_o    (tick8),
		.tick16_o   (tick16),
		.tick128_o  (tick128)
	);

	pin_request_detect u_detect_a
	(
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.pin_n_i    (shutdown_req_pin_a_n_i),
		.mode_i     (pin_a_detect_mode),
		.tick8_i    (tick8),
		.tick16_i   (tick16),
		.tick128_i  (tick128),
		.accept_o   (accept_a),
		.pin_high_o (pin_high_a)
	);

	// same encoding and detector as pin a
	pin_request_detect u_detect_b
	(
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.pin_n_i    (shutdown_req_pin_b_n_i),
		.mode_i     (pin_b_detect_mode),
		.tick8_i    (tick8),
		.tick16_i   (tick16),
		.tick128_i  (tick128),
		.accept_o   (accept_b),
		.pin_high_o (pin_high_b)
	);

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	wire sel_a      = reg_addr_i == `CTRL_A_OFFSET;
	wire sel_b      = reg_addr_i == `CTRL_B_OFFSET;
	wire sel_status = reg_addr_i == `IRQ_STATUS_OFFSET;
	wire sel_mask   = reg_addr_i == `IRQ_MASK_OFFSET;
	wire wr_a       = reg_wr_i & sel_a;
	wire wr_b       = reg_wr_i & sel_b;
	wire wr_status  = reg_wr_i & sel_status;
	wire wr_mask    = reg_wr_i & sel_mask;
	wire rd_a       = reg_rd_i & sel_a;
	wire rd_b       = reg_rd_i & sel_b;

	wire detect_mode_type wr_mode = detect_mode_type'(reg_wdata_i[`MODE_MSB:`MODE_LSB]);

	// ------------------------------------------------------------------
	// flag next values
	// ------------------------------------------------------------------
	wire clr_a = wr_a & ~reg_wdata_i[`FLAG_BIT] & read_one_a
	             & clear_allowed(pin_a_detect_mode, pin_high_a);
	wire clr_b = wr_b & ~reg_wdata_i[`FLAG_BIT] & read_one_b
	             & clear_allowed(pin_b_detect_mode, pin_high_b);

	// a request in the clearing cycle keeps the flag set
	wire next_flag_a = accept_a | (pin_a_request_flag & ~clr_a);
	wire next_flag_b = accept_b | (pin_b_request_flag & ~clr_b);

	// ------------------------------------------------------------------
	// interrupt status, mask and output
	// ------------------------------------------------------------------
	wire rise_a = next_flag_a & ~pin_a_request_flag;
	wire rise_b = next_flag_b & ~pin_b_request_flag;

	wire [1:0] irq_set;
	assign irq_set[`IRQ_A_BIT] = rise_a & pin_a_irq_enable;
	assign irq_set[`IRQ_B_BIT] = rise_b & pin_b_irq_enable;

	wire [1:0] irq_w1c     = wr_status ? reg_wdata_i[1:0] : 2'h0;
	wire [1:0] next_status = irq_set | (irq_status & ~irq_w1c);
	wire [1:0] next_mask   = wr_mask ? reg_wdata_i[1:0] : irq_mask;
	wire       next_irq    = |(next_status & next_mask);

	// ------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------
	wire [`DATA_W-1:0] image_a = ctrl_image(pin_a_detect_mode, pin_a_irq_enable,
	                                        1'b0, pin_a_request_flag);
	wire [`DATA_W-1:0] image_b = ctrl_image(pin_b_detect_mode, pin_b_irq_enable,
	                                        pin_b_hiz_enable, pin_b_request_flag);

	wire [`DATA_W-1:0] rd_value = sel_a      ? image_a :
	                              sel_b      ? image_b :
	                              sel_status ? {14'h0000, irq_status} :
	                              sel_mask   ? {14'h0000, irq_mask} :
	                              16'h0000;

	// ------------------------------------------------------------------
	// first input control and status
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			pin_a_detect_mode <= mode_falling_edge;
			cfg_locked_a      <= 1'b0;
		end
		else if (wr_a && !cfg_locked_a)
		begin
			pin_a_detect_mode <= wr_mode;
			cfg_locked_a      <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			pin_a_irq_enable   <= 1'b0;
			pin_a_request_flag <= 1'b0;
		end
		else
		begin
			pin_a_irq_enable   <= wr_a ? reg_wdata_i[`IRQ_EN_BIT] : pin_a_irq_enable;
			pin_a_request_flag <= next_flag_a;
		end
	end

	// remembers that software saw the flag set
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			read_one_a <= 1'b0;
		else if (rd_a && pin_a_request_flag)
			read_one_a <= 1'b1;
		else if (wr_a)
			read_one_a <= 1'b0;
	end

	// ------------------------------------------------------------------
	// second input control and status
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			pin_b_detect_mode <= mode_falling_edge;
			pin_b_hiz_enable  <= 1'b0;
			cfg_locked_b      <= 1'b0;
		end
		else if (wr_b && !cfg_locked_b)
		begin
			pin_b_detect_mode <= wr_mode;
			pin_b_hiz_enable  <= reg_wdata_i[`HIZ_EN_BIT];
			cfg_locked_b      <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			pin_b_irq_enable   <= 1'b0;
			pin_b_request_flag <= 1'b0;
		end
		else
		begin
			pin_b_irq_enable   <= wr_b ? reg_wdata_i[`IRQ_EN_BIT] : pin_b_irq_enable;
			pin_b_request_flag <= next_flag_b;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			read_one_b <= 1'b0;
		else if (rd_b && pin_b_request_flag)
			read_one_b <= 1'b1;
		else if (wr_b)
			read_one_b <= 1'b0;
	end

	// ------------------------------------------------------------------
	// interrupt registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			irq_status <= `IRQ_RESET;
			irq_mask   <= `IRQ_RESET;
			irq        <= 1'b0;
		end
		else
		begin
			irq_status <= next_status;
			irq_mask   <= next_mask;
			irq        <= next_irq;
		end
	end

	// ------------------------------------------------------------------
	// high-impedance requests and read data
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			hiz_a <= 1'b0;
			hiz_b <= 1'b0;
			rdata <= 16'h0000;
		end
		else
		begin
			hiz_a <= next_flag_a;
			hiz_b <= next_flag_b & pin_b_hiz_enable;
			rdata <= reg_rd_i ? rd_value : 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign reg_rdata_o          = rdata;
	assign pin_a_request_flag_o = pin_a_request_flag;
	assign pin_b_request_flag_o = pin_b_request_flag;
	assign hiz_req_ch34_o       = hiz_a;
	assign hiz_req_ch0_o        = hiz_b;
	assign irq_o                = irq;

endmodule

//--- bench/shutdown_assertions.sv
// Purpose: port checks for the shutdown input detect block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
`include "shutdown_regs.svh"

module shutdown_assertions
(
	input wire logic [`ADDR_W-1:0] reg_addr_i,
	input wire logic               core_clk_i,
	input wire logic               srst_i,
	input wire logic [`DATA_W-1:0] reg_wdata_i,
	input wire logic               reg_wr_i,
	input wire logic               reg_rd_i,
	input wire logic [`DATA_W-1:0] reg_rdata_o,
	input wire logic               shutdown_req_pin_a_n_i,
	input wire logic               shutdown_req_pin_b_n_i,
	input wire logic               pin_a_request_flag_o,
	input wire logic               pin_b_request_flag_o,
	input wire logic               hiz_req_ch34_o,
	input wire logic               hiz_req_ch0_o,
	input wire logic               irq_o
);
	// ------
	// checks
	// ------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	wire logic is_a = reg_addr_i == `CTRL_A_OFFSET;
	wire logic is_b = reg_addr_i == `CTRL_B_OFFSET;
	wire logic is_map = is_a || is_b || reg_addr_i == `IRQ_STATUS_OFFSET
		|| reg_addr_i == `IRQ_MASK_OFFSET;

	rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
		else $error("read data outside a read cycle");
	resv_a_zero_a: assert property ($past(reg_rd_i && is_a) |-> (reg_rdata_o & 16'hEEFC) == 0)
		else $error("reserved bits of ctrl a read nonzero");
	resv_b_zero_a: assert property ($past(reg_rd_i && is_b) |-> (reg_rdata_o & 16'hECFC) == 0)
		else $error("reserved bits of ctrl b read nonzero");
	unmapped_zero_a: assert property ($past(reg_rd_i && !is_map) |-> reg_rdata_o == 0)
		else $error("unmapped read nonzero");
	hiz_a_follow_a: assert property (hiz_req_ch34_o == pin_a_request_flag_o)
		else $error("ch34 hiz request differs from flag a");
	hiz_b_gated_a: assert property (hiz_req_ch0_o |-> pin_b_request_flag_o)
		else $error("ch0 hiz request without flag b");
	clear_a_write_a: assert property ($fell(pin_a_request_flag_o)
		|-> $past(reg_wr_i && is_a && !reg_wdata_i[12]))
		else $error("flag a cleared without a zero write");
	clear_b_write_a: assert property ($fell(pin_b_request_flag_o)
		|-> $past(reg_wr_i && is_b && !reg_wdata_i[12]))
		else $error("flag b cleared without a zero write");
	set_a_pin_a: assert property ($rose(pin_a_request_flag_o)
		|-> !$past(shutdown_req_pin_a_n_i, 3))
		else $error("flag a set without pin a low");
	irq_cause_a: assert property ($rose(irq_o)
		|-> pin_a_request_flag_o || pin_b_request_flag_o
		|| $past(reg_wr_i && reg_addr_i == `IRQ_MASK_OFFSET))
		else $error("interrupt rose without a flag");
endmodule

bind output_shutdown_input_detect shutdown_assertions chk
(
	.reg_addr_i(reg_addr_i), .core_clk_i(core_clk_i), .srst_i(srst_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .shutdown_req_pin_a_n_i(shutdown_req_pin_a_n_i),
	.shutdown_req_pin_b_n_i(shutdown_req_pin_b_n_i), .irq_o(irq_o),
	.pin_a_request_flag_o(pin_a_request_flag_o), .hiz_req_ch0_o(hiz_req_ch0_o),
	.pin_b_request_flag_o(pin_b_request_flag_o), .hiz_req_ch34_o(hiz_req_ch34_o)
);

//--- bench/fault_source.sv
// Purpose: external fault sources on the two request pins
// Assumes: both pins have pull-ups
// Notes:   a released pin returns to the pull-up level
`timescale 1ns/1ps

module fault_source
(
	input  wire logic hold_a_i,
	input  wire logic hold_b_i,
	output logic      pin_a_n_o,
	output logic      pin_b_n_o
);
	// a source pulls low while it holds, else the pull-up wins
	assign pin_a_n_o = hold_a_i ? 1'h0 : 1'h1;
	assign pin_b_n_o = hold_b_i ? 1'h0 : 1'h1;
endmodule

//--- bench/output_shutdown_input_detect_tb.sv
// Purpose: self-checking bench for the shutdown input detect block
// Assumes: 10 MHz clock, synchronous reset
// Notes:   pins are driven through the fault source model
`timescale 1ns/1ps
`include "shutdown_regs.svh"
`define CHK(nm, e, g) \
	begin \
		n_compared++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("unexpected %s: expected %h, seen %h", nm, e, g); \
		end \
	end

module output_shutdown_input_detect_tb;
	logic        core_clk_i = 1'h0;
	logic        srst_i     = 1'h1;
	logic [19:0] reg_addr_i = 20'h00000;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic        reg_wr_i = 1'h0;
	logic        reg_rd_i = 1'h0;
	logic        hold_a   = 1'h0;
	logic        hold_b   = 1'h0;
	logic [15:0] reg_rdata_o;
	logic        pin_a_n, pin_b_n, fa, fb, h34, h0, irq;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          n;

	always #50 core_clk_i = ~core_clk_i;

	fault_source src (.hold_a_i(hold_a), .hold_b_i(hold_b), .pin_a_n_o(pin_a_n),
		.pin_b_n_o(pin_b_n));
	output_shutdown_input_detect dut (.reg_addr_i(reg_addr_i), .core_clk_i(core_clk_i),
		.srst_i(srst_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .shutdown_req_pin_a_n_i(pin_a_n),
		.shutdown_req_pin_b_n_i(pin_b_n), .pin_a_request_flag_o(fa),
		.pin_b_request_flag_o(fb), .hiz_req_ch34_o(h34), .hiz_req_ch0_o(h0), .irq_o(irq));

	// ------
	// tasks
	// ------
	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic do_reset();
		srst_i <= 1'h1;
		repeat (4) @(posedge core_clk_i);
		srst_i <= 1'h0;
	endtask

	task automatic wr(input logic [19:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'h1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'h0;
	endtask

	task automatic rd(input logic [19:0] a, input logic [15:0] e);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'h1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'h0;
		@(negedge core_clk_i);
		`CHK("read data", e, reg_rdata_o)
	endtask

	task automatic pin(input logic b, input logic v);
		@(posedge core_clk_i);
		if (b)
			hold_b <= v;
		else
			hold_a <= v;
	endtask

	task automatic wait_flag(input logic b, input int lim);
		n = 0;
		while (((b ? fb : fa) !== 1'h1) && n < lim)
		begin
			@(negedge core_clk_i);
			n++;
		end
		if ((b ? fb : fa) !== 1'h1)
		begin
			n_mismatch++;
			summarize();
		end
	endtask

	task automatic edge_pulse(input logic b);
		pin(b, 1'h1);
		repeat (6) @(posedge core_clk_i);
		pin(b, 1'h0);
		wait_flag(b, 12);
	endtask

	// ------
	// scenarios
	// ------
	task automatic s_reset_values();
		wr(20'h8C4C2, 16'h0003);
		rd(`CTRL_A_OFFSET, 16'h0000);
		rd(`CTRL_B_OFFSET, 16'h0000);
		rd(`IRQ_STATUS_OFFSET, 16'h0000);
		rd(20'h8C4C2, 16'h0000);
	endtask

	task automatic s_write_once();
		wr(`CTRL_A_OFFSET, 16'h0100);
		rd(`CTRL_A_OFFSET, 16'h0100);
		wr(`CTRL_A_OFFSET, 16'h0003);
		rd(`CTRL_A_OFFSET, 16'h0000);
		wr(`CTRL_A_OFFSET, 16'h0100);
		wr(`CTRL_B_OFFSET, 16'h0301);
		wr(`CTRL_B_OFFSET, 16'h0002);
		rd(`CTRL_B_OFFSET, 16'h0201);
		wr(`CTRL_B_OFFSET, 16'h0301);
		wr(`IRQ_MASK_OFFSET, 16'h0003);
	endtask

	task automatic s_edge_a();
		edge_pulse(1'h0);
		`CHK("hiz ch34", 1'h1, h34)
		`CHK("irq", 1'h1, irq)
		rd(`CTRL_A_OFFSET, 16'h1100);
		wr(`CTRL_A_OFFSET, 16'h1100);
		wr(`CTRL_A_OFFSET, 16'h0100);
		@(negedge core_clk_i);
		`CHK("flag a", 1'h1, fa)
		rd(`CTRL_A_OFFSET, 16'h1100);
		wr(`CTRL_A_OFFSET, 16'h0100);
		@(negedge core_clk_i);
		`CHK("flag a", 1'h0, fa)
		`CHK("hiz ch34", 1'h0, h34)
		rd(`IRQ_STATUS_OFFSET, 16'h0001);
		wr(`IRQ_STATUS_OFFSET, 16'h0001);
		@(negedge core_clk_i);
		`CHK("irq", 1'h0, irq)
	endtask

	task automatic s_gate_a();
		wr(`CTRL_A_OFFSET, 16'h0000);
		edge_pulse(1'h0);
		rd(`IRQ_STATUS_OFFSET, 16'h0000);
		`CHK("irq", 1'h0, irq)
		rd(`CTRL_A_OFFSET, 16'h1000);
		wr(`CTRL_A_OFFSET, 16'h0000);
	endtask

	task automatic s_sample_b();
		wr(`IRQ_MASK_OFFSET, 16'h0001);
		pin(1'h1, 1'h1);
		repeat (80) @(posedge core_clk_i);
		pin(1'h1, 1'h0);
		repeat (60) @(negedge core_clk_i);
		`CHK("flag b", 1'h0, fb)
		pin(1'h1, 1'h1);
		wait_flag(1'h1, 200);
		`CHK("latency div8", 1'h1, (n >= 120 && n <= 140))
		`CHK("hiz ch0", 1'h1, h0)
		`CHK("irq", 1'h0, irq)
		rd(`IRQ_STATUS_OFFSET, 16'h0002);
		wr(`IRQ_MASK_OFFSET, 16'h0003);
		@(negedge core_clk_i);
		`CHK("irq", 1'h1, irq)
		rd(`CTRL_B_OFFSET, 16'h1301);
		wr(`CTRL_B_OFFSET, 16'h0301);
		@(negedge core_clk_i);
		`CHK("flag b", 1'h1, fb)
		pin(1'h1, 1'h0);
		repeat (8) @(posedge core_clk_i);
		rd(`CTRL_B_OFFSET, 16'h1301);
		wr(`CTRL_B_OFFSET, 16'h0301);
		@(negedge core_clk_i);
		`CHK("flag b", 1'h0, fb)
		`CHK("hiz ch0", 1'h0, h0)
		wr(`IRQ_STATUS_OFFSET, 16'h0002);
	endtask

	task automatic s_after_reset();
		do_reset();
		rd(`CTRL_B_OFFSET, 16'h0000);
		wr(`CTRL_B_OFFSET, 16'h0100);
		wr(`CTRL_A_OFFSET, 16'h0002);
		edge_pulse(1'h1);
		`CHK("hiz ch0", 1'h0, h0)
		rd(`CTRL_B_OFFSET, 16'h1100);
		pin(1'h0, 1'h1);
		wait_flag(1'h0, 300);
		`CHK("latency div16", 1'h1, (n >= 240 && n <= 270))
		pin(1'h0, 1'h0);
		do_reset();
		`CHK("flag a", 1'h0, fa)
		`CHK("flag b", 1'h0, fb)
		`CHK("hiz ch34", 1'h0, h34)
		wr(`CTRL_A_OFFSET, 16'h0003);
		pin(1'h0, 1'h1);
		wait_flag(1'h0, 2200);
		`CHK("latency div128", 1'h1, (n >= 1920 && n <= 2060))
		pin(1'h0, 1'h0);
	endtask

	initial
	begin
		do_reset();
		s_reset_values();
		s_write_once();
		s_edge_a();
		s_gate_a();
		s_sample_b();
		s_after_reset();
		summarize();
	end
endmodule
